// ==== ccms_mode_decoder.sv ====
// Picks the active control loop from the setting and the mode-select levels.
`timescale 1ns/1ps
`include "ccms_regs.svh"
module ccms_mode_decoder
  import ccms_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  ccms_sel_if.dec  sel
);

  logic       trig_q_r;
  logic       rise;
  logic       seen_rise_r;
  ccms_mode_e held_r;
  ccms_mode_e held_nxt;
  ccms_mode_e mode_r;
  ccms_mode_e mode_nxt;

  // Two-bit select code of the three-way setting; 11 has no mode.
  function automatic logic code_valid(input logic a, input logic b);
    return !(a && b);
  endfunction

  function automatic ccms_mode_e code_mode(input logic a, input logic b);
    return a ? CCMS_TRQ : (b ? CCMS_POS : CCMS_SPD);
  endfunction

  assign rise = sel.trig && !trig_q_r;

  // Trigger history; cleared at reset so a trigger already high counts as an edge.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      trig_q_r <= 1'b0;
    end else begin
      trig_q_r <= sel.trig;
    end
  end

  // The committed three-way mode starts in speed and moves only on a valid edge.
  always_comb begin
    held_nxt = held_r;
    if (sel.setting == `CCMS_SET_SPT && rise && code_valid(sel.sel_a, sel.sel_b)) begin // RULE_04 RULE_07
      held_nxt = code_mode(sel.sel_a, sel.sel_b); // RULE_04
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      held_r <= CCMS_SPD; // RULE_05
    end else begin
      held_r <= held_nxt;
    end
  end

  // Helper flag for the checks: a commit edge has been seen in the three-way setting.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      seen_rise_r <= 1'b0;
    end else if (sel.setting == `CCMS_SET_SPT && rise) begin
      seen_rise_r <= 1'b1;
    end
  end

  // Level-driven pairs follow the select level one edge later, without a trigger; fixed settings ignore it.
  always_comb begin
    unique case (sel.setting)
      `CCMS_SET_POS:     mode_nxt = CCMS_POS; // RULE_01
      `CCMS_SET_SPD:     mode_nxt = CCMS_SPD; // RULE_01
      `CCMS_SET_TRQ:     mode_nxt = CCMS_TRQ; // RULE_01
      `CCMS_SET_SPD_POS: mode_nxt = sel.sel_a ? CCMS_POS : CCMS_SPD; // RULE_03
      `CCMS_SET_TRQ_POS: mode_nxt = sel.sel_a ? CCMS_POS : CCMS_TRQ; // RULE_03
      `CCMS_SET_SPD_TRQ: mode_nxt = sel.sel_a ? CCMS_TRQ : CCMS_SPD; // RULE_03
      `CCMS_SET_SPT:     mode_nxt = held_nxt; // RULE_04
      default:           mode_nxt = CCMS_POS;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_r <= CCMS_POS;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  assign sel.mode = mode_r;

  sequence s_spt_steady;
    sel.setting == `CCMS_SET_SPT && $past(sel.setting) == `CCMS_SET_SPT;
  endsequence

  sequence s_valid_commit;
    sel.setting == `CCMS_SET_SPT && rise && !(sel.sel_a && sel.sel_b);
  endsequence

  property p_fixed_mode;
    @(posedge core_clk) disable iff (!arst_n)
    sel.setting <= `CCMS_SET_TRQ |=> sel.mode == ccms_mode_e'($past(sel.setting[1:0]));
  endproperty
  a_fixed_mode: assert property (p_fixed_mode) else $error("fixed setting gave wrong mode"); // RULE_01

  property p_spd_pos;
    @(posedge core_clk) disable iff (!arst_n)
    sel.setting == `CCMS_SET_SPD_POS |=> sel.mode == ($past(sel.sel_a) ? CCMS_POS : CCMS_SPD);
  endproperty
  a_spd_pos: assert property (p_spd_pos) else $error("speed-position select wrong"); // RULE_03

  property p_trq_pos;
    @(posedge core_clk) disable iff (!arst_n)
    sel.setting == `CCMS_SET_TRQ_POS |=> sel.mode == ($past(sel.sel_a) ? CCMS_POS : CCMS_TRQ);
  endproperty
  a_trq_pos: assert property (p_trq_pos) else $error("torque-position select wrong"); // RULE_03

  property p_spd_trq;
    @(posedge core_clk) disable iff (!arst_n)
    sel.setting == `CCMS_SET_SPD_TRQ |=> sel.mode == ($past(sel.sel_a) ? CCMS_TRQ : CCMS_SPD);
  endproperty
  a_spd_trq: assert property (p_spd_trq) else $error("speed-torque select wrong"); // RULE_03

  property p_commit;
    @(posedge core_clk) disable iff (!arst_n)
    s_valid_commit |=> sel.mode == code_mode($past(sel.sel_a), $past(sel.sel_b));
  endproperty
  a_commit: assert property (p_commit) else $error("commit edge did not apply mode"); // RULE_04

  property p_hold_no_edge;
    @(posedge core_clk) disable iff (!arst_n)
    s_spt_steady ##0 !rise |=> $stable(sel.mode);
  endproperty
  a_hold_no_edge: assert property (p_hold_no_edge) else $error("mode moved without edge"); // RULE_04

  property p_power_speed;
    @(posedge core_clk) disable iff (!arst_n)
    sel.setting == `CCMS_SET_SPT && !seen_rise_r && !rise |=> sel.mode == CCMS_SPD;
  endproperty
  a_power_speed: assert property (p_power_speed) else $error("not speed before edge"); // RULE_05

  property p_both_high;
    @(posedge core_clk) disable iff (!arst_n)
    s_spt_steady ##0 (rise && sel.sel_a && sel.sel_b) |=> $stable(sel.mode);
  endproperty
  a_both_high: assert property (p_both_high) else $error("undefined code changed mode"); // RULE_07

endmodule

// ==== ccms_pkg.sv ====
// Types shared by the mode selector modules.
package ccms_pkg;

  // Active control loop; order gives position 0, speed 1, torque 2.
  typedef enum logic [1:0] {
    CCMS_POS,
    CCMS_SPD,
    CCMS_TRQ
  } ccms_mode_e;

  typedef logic [2:0] ccms_setting_t;
  typedef logic [7:0] ccms_func_t;

endpackage

// ==== ccms_regs.svh ====
// Register offsets, field positions, reset values and codes of the mode selector.
`ifndef CCMS_REGS_SVH
`define CCMS_REGS_SVH

`define CCMS_OFF_MODE_CFG   8'h00
`define CCMS_OFF_STATUS     8'h04
`define CCMS_OFF_TERM_BASE  8'h10

`define CCMS_MODE_CFG_RST   3'h0
`define CCMS_SET_POS        3'h0
`define CCMS_SET_SPD        3'h1
`define CCMS_SET_TRQ        3'h2
`define CCMS_SET_SPD_POS    3'h3
`define CCMS_SET_TRQ_POS    3'h4
`define CCMS_SET_SPD_TRQ    3'h5
`define CCMS_SET_SPT        3'h6
`define CCMS_SET_MAX        3'h6

`define CCMS_FN_NONE        8'h00
`define CCMS_FN_SEL_A       8'h0b
`define CCMS_FN_SEL_B       8'h1a
`define CCMS_FN_TRIG        8'h1b

`define CCMS_ST_MODE_LSB    0
`define CCMS_ST_MODE_MSB    1
`define CCMS_ST_SEL_A_BIT   4
`define CCMS_ST_SEL_B_BIT   5
`define CCMS_ST_TRIG_BIT    6
`define CCMS_CFG_MSB        2
`define CCMS_FN_MSB         7

`define CCMS_RESP_OKAY      2'h0
`define CCMS_RESP_SLVERR    2'h2

`endif

// ==== ccms_sel_if.sv ====
// Carrier between the register front end and the mode decoder.
`timescale 1ns/1ps
interface ccms_sel_if;
  import ccms_pkg::*;

  ccms_setting_t setting;
  logic          sel_a;
  logic          sel_b;
  logic          trig;
  ccms_mode_e    mode;

  modport ctl (output setting, output sel_a, output sel_b, output trig, input mode);
  modport dec (input setting, input sel_a, input sel_b, input trig, output mode);
endinterface

// ==== ccms_top.sv ====
// Combined control mode selector with its AXI4-Lite register front end.
//
// Notes on behaviour
// [RULE_01] Setting codes 0..6, reset value 0.
// [RULE_02] Terminals take functions 0x0B, 0x1A, 0x1B, level-sensed.
// [RULE_03] Settings 3/4/5 follow first select level.
// [RULE_04] Setting 6 decodes selects, applies on trigger rise.
// [RULE_05] Setting 6 starts in speed until first rise.
// [RULE_06] Upper controller drives selects and raises trigger.
// [RULE_07] Select code 11 on commit keeps mode.
`timescale 1ns/1ps
`include "ccms_regs.svh"
module ccms_top
  import ccms_pkg::*;
#(
  parameter int N_TERM = 8,
  parameter int ADDR_W = 8
) (
  input  wire logic              core_clk,
  input  wire logic              arst_n,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [N_TERM-1:0] term_in,
  output logic [1:0]             active_mode
);

  ccms_setting_t           control_mode_setting_r;
  ccms_func_t              func_r [N_TERM];
  logic                    aw_held_r;
  logic [ADDR_W-1:0]       aw_addr_r;
  logic                    w_held_r;
  logic [31:0]             w_data_r;
  logic [3:0]              w_strb_r;
  logic                    do_write;
  logic                    bvalid_r;
  logic [1:0]              bresp_r;
  logic                    rvalid_r;
  logic [31:0]             rdata_r;
  logic [1:0]              rresp_r;
  logic [N_TERM-1:0]       mask_a;
  logic [N_TERM-1:0]       mask_b;
  logic [N_TERM-1:0]       mask_t;
  logic                    mode_select_a;
  logic                    mode_select_b;
  logic                    mode_commit;

  ccms_sel_if sel ();

  // Terminal slot of a byte address, or N_TERM when the address is no terminal slot.
  function automatic int term_idx(input logic [ADDR_W-1:0] addr);
    int idx;
    idx = N_TERM;
    if (addr >= ADDR_W'(`CCMS_OFF_TERM_BASE) && addr[1:0] == 2'h0) begin
      idx = int'((addr - ADDR_W'(`CCMS_OFF_TERM_BASE)) >> 2);
      if (idx >= N_TERM) begin
        idx = N_TERM;
      end
    end
    return idx;
  endfunction

  // True for any address that answers OKAY.
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
    return addr == ADDR_W'(`CCMS_OFF_MODE_CFG) || addr == ADDR_W'(`CCMS_OFF_STATUS)
           || term_idx(addr) != N_TERM;
  endfunction

  // Terminals whose assigned function matches the given code.
  function automatic logic [N_TERM-1:0] fn_mask(input ccms_func_t code);
    logic [N_TERM-1:0] m;
    m = '0;
    for (int i = 0; i < N_TERM; i++) begin
      m[i] = (func_r[i] == code);
    end
    return m;
  endfunction

  // Functions are pure levels: any terminal carrying a function asserts it.
  assign mask_a        = fn_mask(`CCMS_FN_SEL_A); // RULE_02
  assign mask_b        = fn_mask(`CCMS_FN_SEL_B); // RULE_02
  assign mask_t        = fn_mask(`CCMS_FN_TRIG); // RULE_02
  assign mode_select_a = |(term_in & mask_a); // RULE_02 RULE_06
  assign mode_select_b = |(term_in & mask_b); // RULE_02 RULE_06
  assign mode_commit   = |(term_in & mask_t); // RULE_02 RULE_06

  assign sel.setting = control_mode_setting_r;
  assign sel.sel_a   = mode_select_a;
  assign sel.sel_b   = mode_select_b;
  assign sel.trig    = mode_commit;
  assign active_mode = sel.mode;

  ccms_mode_decoder u_dec (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .sel      (sel.dec)
  );

  // Address and data are parked separately so the master may offer them in either order.
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;
  assign do_write      = aw_held_r && w_held_r && !bvalid_r;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      w_held_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_r <= 1'b0;
    end
  end

  // Write response; only one write is in flight, so a single flag suffices.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `CCMS_RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r  <= addr_mapped(aw_addr_r) ? `CCMS_RESP_OKAY : `CCMS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;

  // Mode setting; codes above six are dropped so the decoder never sees one.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      control_mode_setting_r <= `CCMS_MODE_CFG_RST; // RULE_01
    end else if (do_write && w_strb_r[0] && aw_addr_r == ADDR_W'(`CCMS_OFF_MODE_CFG)
                 && w_data_r[`CCMS_CFG_MSB:0] <= `CCMS_SET_MAX) begin
      control_mode_setting_r <= w_data_r[`CCMS_CFG_MSB:0]; // RULE_01
    end
  end

  // Terminal function table, one byte-wide code per terminal.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < N_TERM; i++) begin
        func_r[i] <= `CCMS_FN_NONE;
      end
    end else if (do_write && w_strb_r[0] && term_idx(aw_addr_r) != N_TERM) begin
      func_r[term_idx(aw_addr_r)] <= w_data_r[`CCMS_FN_MSB:0]; // RULE_02
    end
  end

  // Read data; status shows the live loop choice and the sensed function levels.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= `CCMS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rdata_r  <= '0;
      rresp_r  <= addr_mapped(s_axi_araddr) ? `CCMS_RESP_OKAY : `CCMS_RESP_SLVERR;
      if (s_axi_araddr == ADDR_W'(`CCMS_OFF_MODE_CFG)) begin
        rdata_r[`CCMS_CFG_MSB:0] <= control_mode_setting_r;
      end else if (s_axi_araddr == ADDR_W'(`CCMS_OFF_STATUS)) begin
        rdata_r[`CCMS_ST_MODE_MSB:`CCMS_ST_MODE_LSB] <= sel.mode;
        rdata_r[`CCMS_ST_SEL_A_BIT] <= mode_select_a;
        rdata_r[`CCMS_ST_SEL_B_BIT] <= mode_select_b;
        rdata_r[`CCMS_ST_TRIG_BIT]  <= mode_commit;
      end else if (term_idx(s_axi_araddr) != N_TERM) begin
        rdata_r[`CCMS_FN_MSB:0] <= func_r[term_idx(s_axi_araddr)];
      end
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  property p_sel_a_route;
    @(posedge core_clk) disable iff (!arst_n)
    (func_r[0] == `CCMS_FN_SEL_A && term_in[0] && (term_in & mask_b) == '0)
    |-> mode_select_a && !mode_select_b;
  endproperty
  a_sel_a_route: assert property (p_sel_a_route) else $error("first select not routed"); // RULE_02

  property p_trig_route;
    @(posedge core_clk) disable iff (!arst_n)
    (term_in == '0) |-> !mode_commit && !mode_select_a && !mode_select_b;
  endproperty
  a_trig_route: assert property (p_trig_route) else $error("function seen with inputs low"); // RULE_02

  property p_cfg_write;
    @(posedge core_clk) disable iff (!arst_n)
    (do_write && w_strb_r[0] && aw_addr_r == ADDR_W'(`CCMS_OFF_MODE_CFG)
     && w_data_r[`CCMS_CFG_MSB:0] > `CCMS_SET_MAX) |=> $stable(control_mode_setting_r);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("illegal setting accepted"); // RULE_01

  property p_bresp_follows;
    @(posedge core_clk) disable iff (!arst_n)
    do_write |=> s_axi_bvalid ##0 !s_axi_awready && !s_axi_wready;
  endproperty
  a_bresp_follows: assert property (p_bresp_follows) else $error("write answer missing");

  property p_read_answer;
    @(posedge core_clk) disable iff (!arst_n)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer missing");

  // The other two functions reach their lines; these checks assume at least three terminals.
  property p_sel_b_route;
    @(posedge core_clk) disable iff (!arst_n)
    (func_r[1] == `CCMS_FN_SEL_B && term_in[1]) |-> mode_select_b;
  endproperty
  a_sel_b_route: assert property (p_sel_b_route) else $error("second select lost"); // RULE_02

  property p_commit_route;
    @(posedge core_clk) disable iff (!arst_n)
    (func_r[2] == `CCMS_FN_TRIG && term_in[2]) |-> mode_commit;
  endproperty
  a_commit_route: assert property (p_commit_route) else $error("commit not routed"); // RULE_02

  // With no terminal assigned, toggling inputs must not leak into any function.
  property p_no_func;
    @(posedge core_clk) disable iff (!arst_n)
    (mask_a | mask_b | mask_t) == '0 |-> !mode_select_a && !mode_select_b && !mode_commit;
  endproperty
  a_no_func: assert property (p_no_func) else $error("unassigned terminal acted"); // RULE_02

  // The setting register never holds a code that the decoder has no mode for.
  property p_setting_legal;
    @(posedge core_clk) disable iff (!arst_n)
    control_mode_setting_r <= `CCMS_SET_MAX;
  endproperty
  a_setting_legal: assert property (p_setting_legal) else $error("illegal setting"); // RULE_01

  // A legal setting written through byte 0 lands at the edge that raises the answer.
  property p_cfg_apply;
    @(posedge core_clk) disable iff (!arst_n)
    (do_write && w_strb_r[0] && aw_addr_r == ADDR_W'(`CCMS_OFF_MODE_CFG)
     && w_data_r[`CCMS_CFG_MSB:0] <= `CCMS_SET_MAX)
    |=> control_mode_setting_r == $past(w_data_r[`CCMS_CFG_MSB:0]);
  endproperty
  a_cfg_apply: assert property (p_cfg_apply) else $error("legal setting not taken"); // RULE_01

  // A function code written to the first terminal slot is stored there.
  property p_term_write;
    @(posedge core_clk) disable iff (!arst_n)
    (do_write && w_strb_r[0] && aw_addr_r == ADDR_W'(`CCMS_OFF_TERM_BASE))
    |=> func_r[0] == $past(w_data_r[`CCMS_FN_MSB:0]);
  endproperty
  a_term_write: assert property (p_term_write) else $error("function not stored"); // RULE_02

  // Writes outside the map are answered with an error.
  property p_wr_slverr;
    @(posedge core_clk) disable iff (!arst_n)
    do_write && !addr_mapped(aw_addr_r) |=> s_axi_bresp == `CCMS_RESP_SLVERR;
  endproperty
  a_wr_slverr: assert property (p_wr_slverr) else $error("unmapped write not refused");

  // Address and data offered together: one cycle to commit, one more to answer.
  sequence s_wr_accept;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  property p_wr_turnaround;
    @(posedge core_clk) disable iff (!arst_n)
    s_wr_accept |=> do_write ##1 s_axi_bvalid;
  endproperty
  a_wr_turnaround: assert property (p_wr_turnaround) else $error("write answer late");

  // Read data are taken from the registers at the acceptance edge.
  property p_cfg_readback;
    @(posedge core_clk) disable iff (!arst_n)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_W'(`CCMS_OFF_MODE_CFG))
    |=> s_axi_rdata == 32'($past(control_mode_setting_r));
  endproperty
  a_cfg_readback: assert property (p_cfg_readback) else $error("setting read wrong"); // RULE_01

  property p_status_readback;
    @(posedge core_clk) disable iff (!arst_n)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_W'(`CCMS_OFF_STATUS))
    |=> s_axi_rdata[`CCMS_ST_MODE_MSB:`CCMS_ST_MODE_LSB] == $past(active_mode);
  endproperty
  a_status_readback: assert property (p_status_readback) else $error("status mode wrong");

endmodule

// ==== ccms_upper_ctl.sv ====
// Model of the upper controller that drives the digital input terminals.
`timescale 1ns/1ps
module ccms_upper_ctl (
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic [2:0] want,
  output logic      [7:0] term_in
);
  // Terminals 0, 1 and 2 carry first select, second select and commit trigger.
  // The idle terminals toggle every cycle, so a terminal without a function is seen
  // to have no effect instead of resting at a convenient constant.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      term_in <= 8'h00;
    end else begin
      term_in[2:0] <= want;
      term_in[7:3] <= ~term_in[7:3];
    end
  end
endmodule

// ==== tb.sv ====
// Self-checking bench of the combined control mode selector.
`timescale 1ns/1ps
`include "ccms_regs.svh"
module tb;
  import ccms_pkg::*;
  // One row: setting, levels {trigger, second, first} and the loop expected.
  typedef struct packed {
    ccms_setting_t s;
    logic [2:0]    lv;
    ccms_mode_e    m;
  } ccms_row_s;
  localparam ccms_row_s ROWS [18] = '{
    '{3'h0, 3'h7, CCMS_POS}, '{3'h1, 3'h1, CCMS_SPD}, '{3'h2, 3'h6, CCMS_TRQ},
    '{3'h3, 3'h1, CCMS_POS}, '{3'h3, 3'h0, CCMS_SPD}, '{3'h4, 3'h1, CCMS_POS},
    '{3'h4, 3'h2, CCMS_TRQ}, '{3'h5, 3'h1, CCMS_TRQ}, '{3'h5, 3'h0, CCMS_SPD},
    '{3'h6, 3'h1, CCMS_SPD}, '{3'h6, 3'h5, CCMS_TRQ}, '{3'h6, 3'h6, CCMS_TRQ},
    '{3'h6, 3'h2, CCMS_TRQ}, '{3'h6, 3'h6, CCMS_POS}, '{3'h6, 3'h3, CCMS_POS},
    '{3'h6, 3'h7, CCMS_POS}, '{3'h6, 3'h0, CCMS_POS}, '{3'h6, 3'h4, CCMS_SPD}};
  localparam logic [7:0] FN_ADDR [4] = '{8'h10, 8'h14, 8'h18, 8'h2c};
  localparam logic [7:0] FN_CODE [4] = '{`CCMS_FN_SEL_A, `CCMS_FN_SEL_B, `CCMS_FN_TRIG, 8'h0c};
  logic        core_clk = 1'b0;
  logic        arst_n   = 1'b0;
  logic [7:0]  awaddr   = 8'h00;
  logic [7:0]  araddr   = 8'h00;
  logic [31:0] wdata    = 32'h0;
  logic [3:0]  wstrb    = 4'h0;
  logic        awvalid  = 1'b0;
  logic        wvalid   = 1'b0;
  logic        bready   = 1'b0;
  logic        arvalid  = 1'b0;
  logic        rready   = 1'b0;
  logic [2:0]  want     = 3'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rsp, active_mode;
  logic [31:0] rdata, rd;
  logic [7:0]  term_in;
  int          n_mismatch = 0;
  int          n_tests    = 0;
  int          cycles     = 0;

  ccms_top u_dut (
    .core_clk(core_clk), .arst_n(arst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .term_in(term_in), .active_mode(active_mode)
  );
  ccms_upper_ctl u_ctl (.core_clk(core_clk), .arst_n(arst_n), .want(want), .term_in(term_in));

  // Free-running 50 MHz clock.
  initial begin
    forever #10 core_clk = ~core_clk;
  end

  // A few hundred cycles are expected; the ceiling only catches a hang.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Address and data go out together; each is dropped at the edge it is taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    @(posedge core_clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while ((awvalid && awready !== 1'b1) || (wvalid && wready !== 1'b1));
    do @(posedge core_clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge core_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge core_clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // The model registers the levels one edge later and the selector one more.
  task automatic apply(input logic [2:0] lv);
    @(posedge core_clk);
    want <= lv;
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  task automatic cfg_terms();
    for (int i = 0; i < 4; i++) begin
      wr(FN_ADDR[i], {24'h0, FN_CODE[i]}, 4'hf, rsp);
      chk(rsp, `CCMS_RESP_OKAY);
      rd_reg(FN_ADDR[i], rd, rsp);
      chk(rd, {24'h0, FN_CODE[i]});
    end
  endtask

  // Reset, table of ordinary cases, then refusals and a second reset.
  initial begin
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    rd_reg(`CCMS_OFF_MODE_CFG, rd, rsp);
    chk(rd, 32'h0);
    rd_reg(`CCMS_OFF_TERM_BASE, rd, rsp);
    chk(rd, 32'h0);
    chk(active_mode, CCMS_POS);
    cfg_terms();
    foreach (ROWS[i]) begin
      wr(`CCMS_OFF_MODE_CFG, {29'h0, ROWS[i].s}, 4'hf, rsp);
      apply(ROWS[i].lv);
      if (ROWS[i].s == `CCMS_SET_SPT) chk(active_mode, ROWS[i].m);
      else chk(active_mode, ROWS[i].m);
      rd_reg(`CCMS_OFF_STATUS, rd, rsp);
      chk(rd, {25'h0, ROWS[i].lv, 2'h0, ROWS[i].m});
    end
    wr(`CCMS_OFF_MODE_CFG, 32'h7, 4'hf, rsp);
    chk(rsp, `CCMS_RESP_OKAY);
    wr(`CCMS_OFF_MODE_CFG, 32'h3, 4'he, rsp);
    rd_reg(`CCMS_OFF_MODE_CFG, rd, rsp);
    chk(rd, 32'h6);
    wr(8'h08, 32'h1, 4'hf, rsp);
    chk(rsp, `CCMS_RESP_SLVERR);
    rd_reg(8'h0c, rd, rsp);
    chk(rsp, `CCMS_RESP_SLVERR);
    // Trigger low first; a high trigger at release would not commit, since the setting resets to 0 and no terminal has a function.
    apply(3'h0);
    @(posedge core_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk(active_mode, CCMS_POS);
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    cfg_terms();
    wr(`CCMS_OFF_MODE_CFG, {29'h0, `CCMS_SET_SPT}, 4'hf, rsp);
    apply(3'h3);
    chk(active_mode, CCMS_SPD);
    apply(3'h7);
    chk(active_mode, CCMS_SPD);
    report_and_stop();
  end
endmodule
